// ### logic/info_field_select.sv
// selects the 32-bit information field value for the reported condition
`timescale 1ns/1ps
`include "sense_params.svh"

module info_field_select (
  // condition
  input wire logic [4:0] dev_type,
  input wire logic [1:0] info_src,
  input wire logic [3:0] buf_mode,
  input wire logic fixed_mode,
  input wire logic wr_err_pend,
  // values
  input wire logic [31:0] lba,
  input wire logic [31:0] req_len,
  input wire logic [31:0] act_len,
  input wire logic [31:0] buf_blocks,
  input wire logic [31:0] buf_marks,
  input wire logic [31:0] buf_bytes,
  // result
  output logic [31:0] info
);
  import sense_pkg::*;

  logic [31:0] residue;
  logic buffered;

  // two's complement wraps naturally for negative residues
  assign residue = req_len - act_len;
  assign buffered = (buf_mode == `BUF_MODE_1) || (buf_mode == `BUF_MODE_2);

  always_comb begin
    info = lba;
    if (dev_type == `DEV_TAPE && buffered && wr_err_pend) begin
      info = fixed_mode ? (buf_blocks + buf_marks) : buf_bytes;
    end else if (info_src == `INFO_SRC_COPY) begin
      info = residue;
    end else if (info_src == `INFO_SRC_CMD) begin
      info = lba;
    end else begin
      case (dev_type)
        `DEV_DIRECT, `DEV_WORM, `DEV_CDROM, `DEV_OPTICAL: info = lba;
        `DEV_TAPE, `DEV_PRINTER, `DEV_PROCESSOR: info = residue;
        default: info = lba;
      endcase
    end
  end
endmodule

// ### logic/sense_data_builder.sv
// sense data builder: register file, frame assembly and byte stream
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sense_params.svh"

// Notes on behaviour
// - end-of-medium flag driven only for tape and printer classes, else zero
// - tape: flag set forward at early warning, or reverse stopped at partition start
// - length-mismatch flag set when requested and medium block lengths differ
// - direct, write-once, cd and optical types report block address in info
// - tape, printer, processor report requested minus actual, two's complement
// - copy-style commands report requested minus processed blocks in info
// - buffered tape write error reports blocks plus marks, or buffered bytes
// - additional length is fixed at bytes available, never cut by allocation
// - command-specific information in bytes 8 to 11, zero unless the copy-class bit is set
// - info, sense key and detail code fields always present
// - detail code falls back to no-additional-information code
// - qualifier falls back to zero without detailed information
// - failed-unit code zero unless a failed unit is named
// - key-specific bytes follow a layout only when valid flag and key allow
// - illegal request: byte 15 flags and bit pointer, bytes 16-17 field pointer
// - locator bit one for command block, zero for data-out parameters
// - bit pointer names erroneous bit when bit-pointer-valid is set
// - field pointer is zero-based index of erroneous most significant byte
// - recovered, hardware, medium keys report retry count in bytes 16-17
// - not ready reports format progress only for immediate format
// - progress is a numerator over 10000h for the whole format
// - response code 70h for current, 71h for deferred errors
// - valid, code, flags, key, info, length, codes, unit in fixed positions
// - eighteen bytes of sense data available per request
module sense_data_builder (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // sense request from bus phase logic
  input wire logic sense_req,
  input wire logic [7:0] alloc_len,
  // sense byte stream
  output logic sense_valid,
  input wire logic sense_ready,
  output sense_pkg::byte_t sense_data,
  output logic sense_last,
  output logic sense_busy
);
  import sense_pkg::*;

  builder_s s_r;
  builder_s s_nxt;

  // ==========================================================
  // register field views
  logic [31:0] cond;
  logic [31:0] dev;
  logic [31:0] codes;
  logic [31:0] key_spec;
  logic [31:0] blk_len;
  logic [3:0] key;
  logic [4:0] dev_type;
  logic [31:0] info;
  logic end_of_medium_flag;
  logic length_mismatch_flag;
  logic [7:0] detail;
  logic [7:0] qual;
  logic [7:0] unit;
  logic [7:0] ks0;
  logic [15:0] ks_word;
  logic [31:0] cmd_info;
  logic [17:0][7:0] frame_new;
  logic [3:0] w_idx;
  logic [3:0] r_idx;
  logic [7:0] alloc_cut;
  logic w_ok;
  logic r_ok;

  assign cond = s_r.regs[`OFF_COND >> 2];
  assign dev = s_r.regs[`OFF_DEV >> 2];
  assign codes = s_r.regs[`OFF_CODES >> 2];
  assign key_spec = s_r.regs[`OFF_KEY_SPEC >> 2];
  assign blk_len = s_r.regs[`OFF_BLK_LEN >> 2];
  assign key = cond[`COND_KEY_LSB +: 4];
  assign dev_type = dev[`DEV_TYPE_LSB +: 5];

  info_field_select u_info (
    .dev_type(dev_type),
    .info_src(cond[`COND_INFO_SRC_LSB +: 2]),
    .buf_mode(dev[`DEV_BUF_MODE_LSB +: 4]),
    .fixed_mode(cond[`COND_FIXED_MODE]),
    .wr_err_pend(cond[`COND_WR_ERR_PEND]),
    .lba(s_r.regs[`OFF_LBA >> 2]),
    .req_len(s_r.regs[`OFF_REQ_LEN >> 2]),
    .act_len(s_r.regs[`OFF_ACT_LEN >> 2]),
    .buf_blocks(s_r.regs[`OFF_BUF_BLOCKS >> 2]),
    .buf_marks(s_r.regs[`OFF_BUF_MARKS >> 2]),
    .buf_bytes(s_r.regs[`OFF_BUF_BYTES >> 2]),
    .info(info)
  );

  // ==========================================================
  // field encoding
  always_comb begin
    end_of_medium_flag = 1'b0;
    case (dev_type)
      `DEV_TAPE: begin
        // reverse motion reports partition start, forward reports early warning
        if (cond[`COND_REVERSE]) begin
          end_of_medium_flag = cond[`COND_BOP_HIT];
        end else begin
          end_of_medium_flag = cond[`COND_EARLY_WARN];
        end
      end
      `DEV_PRINTER: end_of_medium_flag = cond[`COND_OUT_OF_PAPER];
      default: end_of_medium_flag = 1'b0;
    endcase
  end

  // requested block length low half, medium block length high half
  assign length_mismatch_flag = blk_len[15:0] != blk_len[31:16];

  assign detail = codes[`CODES_DETAIL_KNOWN] ?
                  codes[`CODES_DETAIL_LSB +: 8] : `NO_ADDL_INFO;
  assign qual = codes[`CODES_QUAL_KNOWN] ?
                codes[`CODES_QUAL_LSB +: 8] : `ZERO_BYTE;
  assign unit = codes[`CODES_UNIT_KNOWN] ?
                codes[`CODES_FAILED_UNIT_LSB +: 8] : `ZERO_BYTE;
  assign cmd_info = dev[`DEV_COPY_CLASS] ?
                    s_r.regs[`OFF_CMD_INFO >> 2] : 32'h0000_0000;

  always_comb begin
    ks0 = `ZERO_BYTE;
    ks_word = 16'h0000;
    if (cond[`COND_KEY_SPEC_VALID]) begin
      case (key)
        `KEY_ILLEGAL: begin
          ks0[7] = 1'b1;
          ks0[6] = cond[`COND_CD];
          ks0[3] = cond[`COND_BIT_PTR_VALID];
          ks0[2:0] = cond[`COND_BIT_PTR_LSB +: 3];
          ks_word = key_spec[15:0];
        end
        `KEY_RECOVERED, `KEY_HARDWARE, `KEY_MEDIUM: begin
          ks0 = 8'h80;
          ks_word = key_spec[15:0];
        end
        `KEY_NOT_READY: begin
          if (cond[`COND_IMMED_FMT]) begin
            ks0 = 8'h80;
            ks_word = key_spec[15:0];
          end
        end
        default: begin
          ks0 = `ZERO_BYTE;
          ks_word = 16'h0000;
        end
      endcase
    end
  end

  // frame layout, byte 0 first
  always_comb begin
    frame_new[0] = {cond[`COND_INFO_VALID],
                    cond[`COND_DEFERRED] ? `RESP_DEFERRED : `RESP_CURRENT};
    frame_new[1] = cond[`COND_SEGMENT_LSB +: 8];
    frame_new[2] = {cond[`COND_FILEMARK] && (dev_type == `DEV_TAPE), end_of_medium_flag,
                    length_mismatch_flag, 1'b0, key};
    frame_new[3] = info[31:24];
    frame_new[4] = info[23:16];
    frame_new[5] = info[15:8];
    frame_new[6] = info[7:0];
    frame_new[7] = `SENSE_ADDL_LEN;
    frame_new[8] = cmd_info[31:24];
    frame_new[9] = cmd_info[23:16];
    frame_new[10] = cmd_info[15:8];
    frame_new[11] = cmd_info[7:0];
    frame_new[12] = detail;
    frame_new[13] = qual;
    frame_new[14] = unit;
    frame_new[15] = ks0;
    frame_new[16] = ks_word[15:8];
    frame_new[17] = ks_word[7:0];
  end

  assign w_idx = s_r.aw_addr[5:2];
  assign r_idx = araddr[5:2];
  assign w_ok = s_r.aw_addr[1:0] == 2'b00 && s_r.aw_addr[7:2] < 6'(`NUM_RW_REGS);
  assign r_ok = araddr[7:2] < 6'(`NUM_RW_REGS);
  assign alloc_cut = (alloc_len < `SENSE_TOTAL) ? alloc_len : `SENSE_TOTAL;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // write channel
    if (awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr;
      s_nxt.awready = 1'b0;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
      s_nxt.wready = 1'b0;
    end
    // both halves held: commit by strobe lanes if the address is valid, and answer in the same cycle
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      if (w_ok) begin
        s_nxt.bresp = `RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (s_r.w_strb[b]) begin
            s_nxt.regs[w_idx][8*b +: 8] = s_r.w_data[8*b +: 8];
          end
        end
      end else begin
        s_nxt.bresp = `RESP_SLVERR;
      end
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    // read channel
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if (araddr[1:0] != 2'b00) begin
        s_nxt.rresp = `RESP_SLVERR;
      end else if (r_ok) begin
        s_nxt.rdata = s_r.regs[r_idx];
      end else if (araddr == `OFF_STATUS) begin
        s_nxt.rdata = {6'h00, length_mismatch_flag, end_of_medium_flag,
                       s_r.sent, s_r.limit,
                       6'h00, s_r.state == ST_SEND, s_r.s_valid};
      end else if (araddr == `OFF_INFO_RD) begin
        s_nxt.rdata = info;
      end else begin
        s_nxt.rresp = `RESP_SLVERR;
      end
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    // sense byte stream
    case (s_r.state)
      ST_IDLE: begin
        if (sense_req) begin
          s_nxt.frame = frame_new;
          s_nxt.limit = alloc_cut;
          s_nxt.sent = 8'h00;
          if (alloc_cut != 8'h00) begin
            s_nxt.state = ST_SEND;
            s_nxt.s_valid = 1'b1;
            s_nxt.s_data = frame_new[0];
            s_nxt.s_last = alloc_cut == 8'h01;
            s_nxt.idx = 8'h01;
          end
        end
      end
      ST_SEND: begin
        // a stalled byte holds until the consumer takes it
        if (sense_ready) begin
          s_nxt.sent = s_r.sent + 8'h01;
          if (s_r.s_last) begin
            s_nxt.state = ST_IDLE;
            s_nxt.s_valid = 1'b0;
            s_nxt.s_last = 1'b0;
          end else begin
            s_nxt.s_data = s_r.frame[5'(s_r.idx)];
            s_nxt.s_last = (s_r.idx + 8'h01) == s_r.limit;
            s_nxt.idx = s_r.idx + 8'h01;
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
        s_nxt.s_valid = 1'b0;
        s_nxt.s_last = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
      s_r.state <= ST_IDLE;
      for (int i = 0; i < `NUM_RW_REGS; i++) begin
        s_r.regs[i] <= `REG_RESET;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign sense_valid = s_r.s_valid;
  assign sense_data = s_r.s_data;
  assign sense_last = s_r.s_last;
  assign sense_busy = s_r.state == ST_SEND;
endmodule

// ### pkg/sense_params.svh
// constants for the sense data builder: offsets, fields, reset values, codes
`ifndef SENSE_PARAMS_SVH
`define SENSE_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFF_COND 8'h00
`define OFF_DEV 8'h04
`define OFF_LBA 8'h08
`define OFF_REQ_LEN 8'h0C
`define OFF_ACT_LEN 8'h10
`define OFF_BUF_BLOCKS 8'h14
`define OFF_BUF_MARKS 8'h18
`define OFF_BUF_BYTES 8'h1C
`define OFF_CMD_INFO 8'h20
`define OFF_CODES 8'h24
`define OFF_KEY_SPEC 8'h28
`define OFF_BLK_LEN 8'h2C
`define OFF_STATUS 8'h30
`define OFF_INFO_RD 8'h34
`define NUM_RW_REGS 12
`define REG_RESET 32'h0000_0000

// ==========================================================
// condition register fields
`define COND_KEY_LSB 0
`define COND_FILEMARK 4
`define COND_EARLY_WARN 5
`define COND_REVERSE 6
`define COND_BOP_HIT 7
`define COND_OUT_OF_PAPER 8
`define COND_DEFERRED 9
`define COND_INFO_VALID 10
`define COND_INFO_SRC_LSB 11
`define COND_FIXED_MODE 13
`define COND_WR_ERR_PEND 14
`define COND_KEY_SPEC_VALID 15
`define COND_CD 16
`define COND_BIT_PTR_VALID 17
`define COND_BIT_PTR_LSB 18
`define COND_IMMED_FMT 21
`define COND_SEGMENT_LSB 22

// ==========================================================
// device register fields
`define DEV_TYPE_LSB 0
`define DEV_COPY_CLASS 5
`define DEV_BUF_MODE_LSB 6

// ==========================================================
// codes register fields
`define CODES_DETAIL_LSB 0
`define CODES_QUAL_LSB 8
`define CODES_FAILED_UNIT_LSB 16
`define CODES_DETAIL_KNOWN 24
`define CODES_QUAL_KNOWN 25
`define CODES_UNIT_KNOWN 26

// ==========================================================
// info source selector
`define INFO_SRC_AUTO 2'h0
`define INFO_SRC_COPY 2'h1
`define INFO_SRC_CMD 2'h2

// ==========================================================
// sense encodings
`define RESP_CURRENT 7'h70
`define RESP_DEFERRED 7'h71
`define KEY_NOT_READY 4'h2
`define KEY_RECOVERED 4'h1
`define KEY_MEDIUM 4'h3
`define KEY_HARDWARE 4'h4
`define KEY_ILLEGAL 4'h5
`define NO_ADDL_INFO 8'h00
`define ZERO_BYTE 8'h00
`define SENSE_TOTAL 8'h12
`define SENSE_ADDL_LEN 8'h0A
`define DEV_TAPE 5'h01
`define DEV_PRINTER 5'h02
`define DEV_PROCESSOR 5'h03
`define DEV_DIRECT 5'h00
`define DEV_WORM 5'h04
`define DEV_CDROM 5'h05
`define DEV_OPTICAL 5'h07
`define BUF_MODE_1 4'h1
`define BUF_MODE_2 4'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### pkg/sense_pkg.sv
// types for the sense data builder
package sense_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } stream_state_e;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    word_t w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    word_t rdata;
    logic [1:0] rresp;
    logic [11:0][31:0] regs;
    stream_state_e state;
    logic [17:0][7:0] frame;
    logic [7:0] idx;
    logic [7:0] limit;
    logic [7:0] sent;
    logic s_valid;
    byte_t s_data;
    logic s_last;
  } builder_s;
endpackage

// ### testbench/sense_data_builder_monitor.sv
// concurrent checks on the sense byte stream of the builder
`timescale 1ns/1ps

module sense_data_builder_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write response
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  // sense stream
  input wire logic sense_req,
  input wire logic [7:0] alloc_len,
  input wire logic sense_valid,
  input wire logic sense_ready,
  input wire sense_pkg::byte_t sense_data,
  input wire logic sense_last,
  input wire logic sense_busy
);
  import sense_pkg::*;
  logic [7:0] idx_r;
  logic [7:0] lim_r;
  logic [3:0] key_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // byte position tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r <= 8'h00;
      lim_r <= 8'h00;
      key_r <= 4'h0;
    end else if (sense_req && !sense_busy) begin
      idx_r <= 8'h00;
      lim_r <= (alloc_len > 8'h12) ? 8'h12 : alloc_len;
    end else if (sense_valid && sense_ready) begin
      idx_r <= idx_r + 8'h01;
      if (idx_r == 8'h02) key_r <= sense_data[3:0];
    end
  end

  // ==========================================================
  // assertions
  a_valid_in_busy: assert property (sense_valid |-> sense_busy)
    else $error("byte offered outside a stream");
  a_byte_holds: assert property (sense_valid && !sense_ready |=>
    sense_valid && $stable(sense_data) && $stable(sense_last))
    else $error("stalled byte changed");
  a_first_byte: assert property (sense_req && !sense_busy && alloc_len != 8'h00 |=>
    sense_valid && sense_busy)
    else $error("stream did not start");
  a_zero_alloc: assert property (sense_req && !sense_busy && alloc_len == 8'h00 |=>
    !sense_valid)
    else $error("byte sent with zero allocation");
  a_last_pos: assert property (sense_valid |-> sense_last == (idx_r == lim_r - 8'h01))
    else $error("last flag on wrong byte");
  a_stream_end: assert property (sense_valid && sense_ready && sense_last |=>
    !sense_valid && !sense_busy)
    else $error("stream ran past last byte");
  a_code_byte: assert property (sense_valid && idx_r == 8'h00 |->
    sense_data[6:0] inside {7'h70, 7'h71})
    else $error("bad response code");
  a_addl_len: assert property (sense_valid && idx_r == 8'h07 |-> sense_data == 8'h0A)
    else $error("bad additional length");
  a_flag_rsvd: assert property (sense_valid && idx_r == 8'h02 |-> !sense_data[4])
    else $error("reserved flag bit set");
  a_ks_rsvd: assert property (sense_valid && idx_r > 8'h0E &&
    !(key_r inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5}) |-> sense_data == 8'h00)
    else $error("key specific byte set for key without layout");

  cover property (sense_valid && sense_ready && sense_last && idx_r == 8'h11);
  cover property (sense_req && !sense_busy && alloc_len == 8'h00);
  cover property (bvalid && bresp == 2'h2);
endmodule

bind sense_data_builder sense_data_builder_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .bvalid(bvalid), .bresp(bresp), .sense_req(sense_req), .alloc_len(alloc_len),
  .sense_valid(sense_valid), .sense_ready(sense_ready), .sense_data(sense_data),
  .sense_last(sense_last), .sense_busy(sense_busy));

// ### testbench/sense_data_builder_tb.sv
// self-checking bench for the sense data builder
`timescale 1ns/1ps
`include "sense_params.svh"

module sense_data_builder_tb;
  import sense_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic sense_req = 0, hold = 0, awready, wready, bvalid, arready, rvalid;
  logic sense_valid, sense_ready, sense_last, sense_busy;
  logic [7:0] awaddr = 0, araddr = 0, alloc_len = 0, n_got, last_pos;
  logic [2:0] awprot = 0, arprot = 0;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  word_t wdata = 0, rdata;
  byte_t sense_data;
  logic [17:0][7:0] got;
  word_t regs [12];
  int num_errors = 0, n_tests = 0, cyc = 0;

  always #10 aclk = ~aclk;

  sense_data_builder DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sense_req(sense_req), .alloc_len(alloc_len),
    .sense_valid(sense_valid), .sense_ready(sense_ready), .sense_data(sense_data),
    .sense_last(sense_last), .sense_busy(sense_busy));

  sense_initiator_model u_init (.aclk(aclk), .aresetn(aresetn), .sense_req(sense_req),
    .sense_busy(sense_busy), .sense_valid(sense_valid), .sense_data(sense_data),
    .sense_last(sense_last), .sense_ready(sense_ready), .hold(hold), .n_got(n_got),
    .last_pos(last_pos), .got(got));

  // ==========================================================
  // tasks and expectations
  task automatic results();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input word_t d, output word_t q,
      output logic [1:0] r);
    logic done;
    done = 0;
    if (wr) begin
      awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d; bready <= 1;
    end else begin
      arvalid <= 1; araddr <= a; rready <= 1;
    end
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (arvalid && arready) arvalid <= 0;
      if (wr ? bvalid === 1'b1 : rvalid === 1'b1) begin
        done = 1;
        q = rdata;
        r = wr ? bresp : rresp;
      end
    end
  endtask

  function automatic logic [17:0][7:0] exp_frame();
    logic [17:0][7:0] f;
    word_t c, dv, info;
    logic tape, medium_end;
    c = regs[0]; dv = regs[1]; f = '0;
    tape = dv[4:0] == `DEV_TAPE;
    medium_end = tape ? (c[6] ? c[7] : c[5]) : (dv[4:0] == `DEV_PRINTER) && c[8];
    if (tape && dv[9:6] inside {`BUF_MODE_1, `BUF_MODE_2} && c[14])
      info = c[13] ? regs[5] + regs[6] : regs[7];
    else if (c[12:11] == `INFO_SRC_CMD ||
             (c[12:11] != `INFO_SRC_COPY && dv[4:0] inside {0, 4, 5, 7})) info = regs[2];
    else info = regs[3] - regs[4];
    f[0] = {c[10], c[9] ? `RESP_DEFERRED : `RESP_CURRENT};
    f[1] = c[29:22];
    f[2] = {tape & c[4], medium_end, regs[11][15:0] != regs[11][31:16], 1'b0, c[3:0]};
    {f[3], f[4], f[5], f[6]} = info;
    f[7] = `SENSE_ADDL_LEN;
    if (dv[5]) {f[8], f[9], f[10], f[11]} = regs[8];
    f[12] = regs[9][24] ? regs[9][7:0] : `NO_ADDL_INFO;
    f[13] = regs[9][25] ? regs[9][15:8] : 8'h00;
    f[14] = regs[9][26] ? regs[9][23:16] : 8'h00;
    if (c[15] && (c[3:0] inside {1, 3, 4, 5} || (c[3:0] == 2 && c[21]))) begin
      f[15] = c[3:0] == `KEY_ILLEGAL ? {1'b1, c[16], 2'b00, c[17], c[20:18]} : 8'h80;
      {f[16], f[17]} = regs[10][15:0];
    end
    return f;
  endfunction

  // ==========================================================
  // watchdog and main sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    logic [17:0][7:0] ef;
    word_t q;
    logic [1:0] r;
    logic [7:0] a, n;
    logic [7:0] bad [3] = '{8'h30, 8'h34, 8'h02};
    logic [7:0] a_tbl [6] = '{8'h00, 8'h01, 8'h11, 8'h12, 8'h13, 8'hFF};
    logic [4:0] dev_tbl [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07};
    void'($urandom(32'h06F6));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 12; i++) begin
      bus(0, 8'(i * 4), 0, q, r);
      chk(q, `REG_RESET);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1, bad[i], 32'hFFFF_FFFF, q, r);
      chk(r, `RESP_SLVERR);
    end
    bus(0, 8'h3C, 0, q, r);
    chk({r, q[29:0]}, {`RESP_SLVERR, 30'h0});
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 12; i++) regs[i] = $urandom;
      regs[0][3:0] = 4'($urandom % 6);
      regs[0][12:11] = 2'($urandom % 3);
      regs[1] = regs[1] & 32'h0000_0020;
      regs[1][4:0] = dev_tbl[$urandom % 7];
      regs[1][9:6] = 4'($urandom % 3);
      if (k % 2) regs[11][31:16] = regs[11][15:0];
      for (int i = 0; i < 12; i++) begin
        bus(1, 8'(i * 4), regs[i], q, r);
        chk(r, `RESP_OKAY);
        bus(0, 8'(i * 4), 0, q, r);
        chk(q, regs[i]);
      end
      a = k < 6 ? a_tbl[k] : 8'($urandom % 24);
      n = a > 8'h12 ? 8'h12 : a;
      ef = exp_frame();
      bus(0, `OFF_INFO_RD, 0, q, r);
      chk(q, {ef[3], ef[4], ef[5], ef[6]});
      sense_req <= 1;
      alloc_len <= a;
      @(posedge aclk);
      sense_req <= 0;
      if (a >= 8'h12) begin
        hold <= 1;
        bus(1, `OFF_COND, ~regs[0], q, r);
        sense_req <= 1;
        alloc_len <= 8'h01;
        @(posedge aclk);
        sense_req <= 0;
        hold <= 0;
      end
      repeat (2) @(posedge aclk);
      while (sense_busy === 1'b1) @(posedge aclk);
      chk(n_got, n);
      chk(last_pos, n);
      for (int i = 0; i < 18; i++) if (i < n) chk(got[i], ef[i]);
      if (a < 8'h12) begin
        bus(0, `OFF_STATUS, 0, q, r);
        chk(q, {6'h00, ef[2][5], ef[2][6], n, n, 8'h00});
      end
    end
    // reset in mid-run, then byte-lane strobes on a cleared register
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk({sense_valid, sense_busy, sense_last, bvalid, rvalid}, 5'h00);
    bus(0, `OFF_COND, 0, q, r);
    chk(q, `REG_RESET);
    wstrb <= 4'h5;
    bus(1, `OFF_LBA, 32'hA5A5_A5A5, q, r);
    wstrb <= 4'hF;
    bus(0, `OFF_LBA, 0, q, r);
    chk(q, 32'h00A5_00A5);
    results();
  end
endmodule

// ### testbench/sense_initiator_model.sv
// initiator side: takes sense bytes with random stalls and keeps them
`timescale 1ns/1ps

module sense_initiator_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sense stream
  input wire logic sense_req,
  input wire logic sense_busy,
  input wire logic sense_valid,
  input wire sense_pkg::byte_t sense_data,
  input wire logic sense_last,
  output logic sense_ready,
  // control and capture
  input wire logic hold,
  output logic [7:0] n_got,
  output logic [7:0] last_pos,
  output logic [17:0][7:0] got
);
  import sense_pkg::*;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sense_ready <= 1'b0;
      n_got <= 8'h00;
      last_pos <= 8'h00;
    end else begin
      sense_ready <= !hold && ($urandom % 3 != 0);
      if (sense_req && !sense_busy) begin
        n_got <= 8'h00;
        last_pos <= 8'h00;
      end else if (sense_valid && sense_ready) begin
        if (n_got < 8'h12) got[n_got] <= sense_data;
        n_got <= n_got + 8'h01;
        if (sense_last) last_pos <= n_got + 8'h01;
      end
    end
  end
endmodule
